// ===== hdl/cmd_handler_pkg.sv
// Package with the types and constants shared by the common command handler files.
package cmd_handler_pkg;

   // Commands delivered by the message parser, one per transfer.
   typedef enum logic [3:0] {
      OP_IDN_Q,
      OP_RST,
      OP_TST_Q,
      OP_OPC,
      OP_OPC_Q,
      OP_WAI,
      OP_CLS,
      OP_LEVEL_SET,
      OP_LEVEL_Q,
      OP_MEAS_Q,
      OP_DEV_CMD
   } opcode_e;

   // Kind of answer placed in the output slot.
   typedef enum logic [1:0] {
      RESP_IDN,
      RESP_NR1,
      RESP_OPC,
      RESP_LEVEL
   } resp_kind_e;

   // Measurement signal level settings.
   typedef enum logic {
      LEVEL_1V,
      LEVEL_500MV
   } level_e;

   // Numeric parameter: value = mantissa * 10 ** exponent.
   typedef struct packed {
      logic [15:0] mantissa;
      logic signed [4:0] exponent;
   } number_s;

   typedef struct packed {
      opcode_e opcode;
      number_s number;
   } command_s;

   // One answer; the text formatter turns it into the reply message.
   typedef struct packed {
      resp_kind_e kind;
      logic [15:0] maker;
      logic [15:0] model;
      logic [7:0] zero_field;
      logic [15:0] fw_version;
      logic [15:0] value;
   } response_s;

   localparam logic [7:0] IDN_ZERO_FIELD = 8'h00;
   localparam logic [15:0] OPC_ASCII_ONE = 16'h0031;
   localparam logic [3:0] TST_FAULT_MASK = 4'hF;
   localparam int SESR_OPC_BIT = 0;
   localparam int SESR_EXE_BIT = 4;
   localparam logic [7:0] SESR_RESET = 8'h00;
   localparam logic [7:0] DEV_EVENT_RESET = 8'h00;
   localparam level_e LEVEL_RESET = LEVEL_1V;
   localparam logic [15:0] LEVEL_1V_MV = 16'h03E8;
   localparam logic [15:0] LEVEL_500MV_MV = 16'h01F4;
   localparam int MV_EXP_SHIFT = 3;
   localparam int MAX_DECADE = 9;

endpackage

// ===== hdl/level_number_decoder.sv
// Rounds a numeric parameter to whole millivolts and checks it against the legal levels.
`timescale 1ns/100ps
`default_nettype none
module level_number_decoder (
   input wire cmd_handler_pkg::number_s number,
   output cmd_handler_pkg::level_e level,
   output logic level_ok
);

   // Power of ten as a 32-bit constant, saturated at the largest decade handled.
   function automatic logic [31:0] pow10(input int k);
      logic [31:0] p;
      p = 32'h0000_0001;
      for (int i = 0; i < cmd_handler_pkg::MAX_DECADE; i++) begin
         if (i < k) begin
            p = p * 32'h0000_000A;
         end
      end
      return p;
   endfunction

   int shift;
   logic [31:0] mv;
   logic [31:0] scale;
   logic [47:0] wide;

   // Integer, fixed and floating forms all arrive as mantissa and exponent; the
   // value is scaled to millivolts once and rounded half up in a single division
   // so that no digit is rounded twice.
   always_comb begin
      shift = int'(number.exponent) + cmd_handler_pkg::MV_EXP_SHIFT;
      mv = 32'h0000_0000;
      scale = 32'h0000_0001;
      wide = 48'h0000_0000_0000;
      if (shift >= 0) begin
         scale = pow10(shift);
         wide = {32'h0000_0000, number.mantissa} * {16'h0000, scale};
         mv = (wide[47:32] != 16'h0000) ? 32'hFFFF_FFFF : wide[31:0];
      end else if (-shift > cmd_handler_pkg::MAX_DECADE) begin
         mv = 32'h0000_0000;
      end else begin
         scale = pow10(-shift);
         mv = ({16'h0000, number.mantissa} + (scale >> 1)) / scale;
      end
   end

   // Only 1 V and 500 mV are legal settings.
   always_comb begin
      level_ok = 1'b1;
      level = cmd_handler_pkg::LEVEL_1V;
      if (mv == {16'h0000, cmd_handler_pkg::LEVEL_500MV_MV}) begin
         level = cmd_handler_pkg::LEVEL_500MV;
      end else if (mv != {16'h0000, cmd_handler_pkg::LEVEL_1V_MV}) begin
         level_ok = 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/common_command_handler.sv
// Common command handler: identification, self test, sync, status clearing and signal level.
// Functional notes
// - An identification query answers maker, model, a constant zero and the firmware version.
// - A self-test query runs the test and answers 0 to 15 with ROM, RAM, I/O, interrupt faults.
// - The operation-complete command sets event bit 0 once all earlier commands have finished.
// - The operation-complete query answers ASCII 1 only after all earlier commands have finished.
// - The wait command holds back later commands until all earlier ones have finished.
// - Device commands run one after another and only the measurement fetch query may overlap.
// - Clear status zeroes the standard event register and the four device event registers.
// - Clear status over the serial port leaves the output queue alone.
// - Clear status over the instrument bus leaves the output queue and message-available bit.
// - The signal level accepts only 1 or 0.5 and its query answers the setting in fixed point.
// - Numbers are accepted as integer, fixed or floating point and rounded to their resolution.
`timescale 1ns/100ps
`default_nettype none
module common_command_handler #(
   parameter logic [15:0] MAKER_CODE = 16'h4D4B,   // Arbitrary value.
   parameter logic [15:0] MODEL_CODE = 16'h0001,   // Arbitrary value.
   parameter logic [15:0] FW_VERSION = 16'h0100,
   parameter int FETCH_CNT_W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire cmd_handler_pkg::command_s cmd,
   output logic cmd_ready,
   output logic resp_valid,
   input wire logic resp_ready,
   output cmd_handler_pkg::response_s resp,
   output logic msg_available,
   input wire logic port_is_gpib,
   output logic dev_req,
   input wire logic dev_done,
   output logic meas_req,
   input wire logic meas_done,
   output logic selftest_req,
   input wire logic selftest_done,
   input wire logic [3:0] selftest_faults,
   output logic settings_reset,
   output cmd_handler_pkg::level_e signal_level,
   input wire logic [7:0] sesr_set,
   input wire logic [3:0][7:0] dev_event_set,
   output logic [7:0] sesr,
   output logic [7:0] device_event_reg_a,
   output logic [7:0] device_event_reg_b,
   output logic [7:0] device_event_reg_c,
   output logic [7:0] device_event_reg_d
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEQ,
      ST_DRAIN,
      ST_TEST
   } state_e;

   typedef struct packed {
      state_e state;
      cmd_handler_pkg::opcode_e held_op;
      logic [FETCH_CNT_W-1:0] fetch_cnt;
      logic [7:0] sesr;
      logic [3:0][7:0] dev_ev;
      cmd_handler_pkg::level_e level;
      logic resp_valid;
      cmd_handler_pkg::response_s resp;
      logic dev_req;
      logic meas_req;
      logic selftest_req;
      logic settings_reset;
   } handler_s;

   handler_s s_r;
   handler_s s_nxt;
   cmd_handler_pkg::level_e dec_level;
   logic dec_ok;
   logic is_query;
   logic take;

   level_number_decoder u_level_dec (
      .number(cmd.number),
      .level(dec_level),
      .level_ok(dec_ok)
   );

   // Commands that produce an answer wait while the output slot is still full.
   always_comb begin
      case (cmd.opcode)
         cmd_handler_pkg::OP_IDN_Q,
         cmd_handler_pkg::OP_TST_Q,
         cmd_handler_pkg::OP_OPC_Q,
         cmd_handler_pkg::OP_LEVEL_Q: is_query = 1'b1;
         default: is_query = 1'b0;
      endcase
   end

   // Sequential commands, drains and the self test all leave the idle state.
   assign cmd_ready = (s_r.state == ST_IDLE) && !(is_query && s_r.resp_valid);
   assign take = cmd_valid && cmd_ready;

   // Builds an answer with the fixed identity fields filled in.
   function automatic cmd_handler_pkg::response_s make_resp(
      input cmd_handler_pkg::resp_kind_e kind,
      input logic [15:0] value
   );
      cmd_handler_pkg::response_s r;
      r.kind = kind;
      r.maker = MAKER_CODE;
      r.model = MODEL_CODE;
      r.zero_field = cmd_handler_pkg::IDN_ZERO_FIELD;
      r.fw_version = FW_VERSION;
      r.value = value;
      return r;
   endfunction

   // Next-state logic for the whole handler.
   always_comb begin
      s_nxt = s_r;
      s_nxt.dev_req = 1'b0;
      s_nxt.meas_req = 1'b0;
      s_nxt.selftest_req = 1'b0;
      s_nxt.settings_reset = 1'b0;
      if (s_r.resp_valid && resp_ready) begin
         s_nxt.resp_valid = 1'b0;
      end
      // Outstanding fetches are the only work that overlaps later commands.
      s_nxt.fetch_cnt = s_r.fetch_cnt + FETCH_CNT_W'(s_r.meas_req) - FETCH_CNT_W'(meas_done);
      case (s_r.state)
         ST_IDLE: begin
            if (take) begin
               case (cmd.opcode)
                  cmd_handler_pkg::OP_IDN_Q: begin
                     s_nxt.resp = make_resp(cmd_handler_pkg::RESP_IDN, 16'h0000);
                     s_nxt.resp_valid = 1'b1;
                  end
                  cmd_handler_pkg::OP_RST: begin
                     s_nxt.level = cmd_handler_pkg::LEVEL_RESET;
                     s_nxt.settings_reset = 1'b1;
                  end
                  cmd_handler_pkg::OP_TST_Q: begin
                     s_nxt.selftest_req = 1'b1;
                     s_nxt.state = ST_TEST;
                  end
                  cmd_handler_pkg::OP_OPC,
                  cmd_handler_pkg::OP_OPC_Q,
                  cmd_handler_pkg::OP_WAI: begin
                     s_nxt.held_op = cmd.opcode;
                     s_nxt.state = ST_DRAIN;
                  end
                  cmd_handler_pkg::OP_CLS: begin
                     // Output slot and its available flag are kept on both ports.
                     s_nxt.sesr = cmd_handler_pkg::SESR_RESET;
                     s_nxt.dev_ev = {4{cmd_handler_pkg::DEV_EVENT_RESET}};
                  end
                  cmd_handler_pkg::OP_LEVEL_SET: begin
                     if (dec_ok) begin
                        s_nxt.level = dec_level;
                     end else begin
                        s_nxt.sesr[cmd_handler_pkg::SESR_EXE_BIT] = 1'b1;
                     end
                  end
                  cmd_handler_pkg::OP_LEVEL_Q: begin
                     // Millivolts with three implied decimals, printed as 1 or 0.5.
                     s_nxt.resp = make_resp(cmd_handler_pkg::RESP_LEVEL,
                        (s_r.level == cmd_handler_pkg::LEVEL_1V) ?
                        cmd_handler_pkg::LEVEL_1V_MV : cmd_handler_pkg::LEVEL_500MV_MV);
                     s_nxt.resp_valid = 1'b1;
                  end
                  cmd_handler_pkg::OP_MEAS_Q: begin
                     s_nxt.meas_req = 1'b1;
                  end
                  default: begin
                     s_nxt.dev_req = 1'b1;
                     s_nxt.state = ST_SEQ;
                  end
               endcase
            end
         end
         ST_SEQ: begin
            if (dev_done) begin
               s_nxt.state = ST_IDLE;
            end
         end
         ST_DRAIN: begin
            // Acts only once no fetch is in flight or about to start.
            if (s_r.fetch_cnt == '0 && !s_r.meas_req) begin
               s_nxt.state = ST_IDLE;
               if (s_r.held_op == cmd_handler_pkg::OP_OPC) begin
                  s_nxt.sesr[cmd_handler_pkg::SESR_OPC_BIT] = 1'b1;
               end else if (s_r.held_op == cmd_handler_pkg::OP_OPC_Q) begin
                  s_nxt.resp = make_resp(cmd_handler_pkg::RESP_OPC,
                     cmd_handler_pkg::OPC_ASCII_ONE);
                  s_nxt.resp_valid = 1'b1;
               end
            end
         end
         ST_TEST: begin
            if (selftest_done) begin
               s_nxt.resp = make_resp(cmd_handler_pkg::RESP_NR1,
                  {12'h000, selftest_faults & cmd_handler_pkg::TST_FAULT_MASK});
               s_nxt.resp_valid = 1'b1;
               s_nxt.state = ST_IDLE;
            end
         end
         default: begin
            s_nxt.state = ST_IDLE;
         end
      endcase
      // Events set after any clear, so an event in the clearing cycle survives.
      s_nxt.sesr = s_nxt.sesr | sesr_set;
      for (int i = 0; i < 4; i++) begin
         s_nxt.dev_ev[i] = s_nxt.dev_ev[i] | dev_event_set[i];
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.state <= ST_IDLE;
         s_r.sesr <= cmd_handler_pkg::SESR_RESET;
         s_r.dev_ev <= {4{cmd_handler_pkg::DEV_EVENT_RESET}};
         s_r.level <= cmd_handler_pkg::LEVEL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs other than cmd_ready come straight from the state register.
   assign resp_valid = s_r.resp_valid;
   assign resp = s_r.resp;
   assign msg_available = s_r.resp_valid;
   assign dev_req = s_r.dev_req;
   assign meas_req = s_r.meas_req;
   assign selftest_req = s_r.selftest_req;
   assign settings_reset = s_r.settings_reset;
   assign signal_level = s_r.level;
   assign sesr = s_r.sesr;
   assign device_event_reg_a = s_r.dev_ev[0];
   assign device_event_reg_b = s_r.dev_ev[1];
   assign device_event_reg_c = s_r.dev_ev[2];
   assign device_event_reg_d = s_r.dev_ev[3];

   // Checks of the documented behaviour.
   AST_IDN_FIELDS: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_IDN_Q |=> resp_valid
      && resp.kind == cmd_handler_pkg::RESP_IDN && resp.zero_field == 8'h00
      && resp.maker == MAKER_CODE && resp.model == MODEL_CODE && resp.fw_version == FW_VERSION)
      else $error("Identification answer is wrong.");

   AST_TST_RANGE: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_TEST && selftest_done |=> resp_valid
      && resp.value == {12'h000, $past(selftest_faults)})
      else $error("Self test answer is wrong.");

   AST_OPC_WAITS: assert property (@(posedge clk) disable iff (rst)
      $rose(sesr[0]) && $past(s_r.state) == ST_DRAIN |-> $past(s_r.fetch_cnt) == '0)
      else $error("Operation complete set while a fetch was pending.");

   AST_OPCQ_ONE: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_DRAIN && s_r.held_op == cmd_handler_pkg::OP_OPC_Q
      && s_r.fetch_cnt == '0 && !s_r.meas_req
      |=> resp_valid && resp.value == 16'h0031 && s_r.state == ST_IDLE)
      else $error("Operation complete query did not answer one.");

   AST_WAI_HOLDS: assert property (@(posedge clk) disable iff (rst)
      s_r.state == ST_DRAIN && s_r.fetch_cnt != '0 |-> !cmd_ready)
      else $error("Command taken during a wait.");

   AST_SEQ_HOLDS: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_DEV_CMD
      |=> dev_req && !cmd_ready && s_r.state == ST_SEQ)
      else $error("Device command did not run sequentially.");

   AST_CLS_CLEARS: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_CLS && sesr_set == 8'h00
      && dev_event_set == '0 |=> sesr == 8'h00 && device_event_reg_a == 8'h00
      && device_event_reg_d == 8'h00)
      else $error("Clear status left an event bit set.");

   AST_CLS_KEEPS_QUEUE: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_CLS && resp_valid && !resp_ready
      |=> resp_valid && msg_available && $stable(resp))
      else $error("Clear status disturbed the output queue.");

   AST_LEVEL_BAD: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_LEVEL_SET && !dec_ok
      |=> $stable(signal_level) && sesr[4])
      else $error("Illegal level was not refused.");

   AST_RST_LEVEL: assert property (@(posedge clk) disable iff (rst)
      take && cmd.opcode == cmd_handler_pkg::OP_RST
      |=> settings_reset && signal_level == cmd_handler_pkg::LEVEL_1V)
      else $error("Reset did not restore the level.");

endmodule
`default_nettype wire

// ===== verif/back_end_model.sv
// Behavioural model of the instrument back end that answers the handler's start pulses.
`timescale 1ns/100ps
`default_nettype none
module back_end_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic dev_req,
   input wire logic meas_req,
   input wire logic selftest_req,
   input wire logic [7:0] delay,
   output logic dev_done,
   output logic meas_done,
   output logic selftest_done
);
   int dev_cnt;
   int meas_cnt;
   int test_cnt;

   // Each start loads a countdown; the done pulse lasts one cycle, delay cycles later.
   always @(negedge clk) begin
      dev_done = (dev_cnt == 1);
      meas_done = (meas_cnt == 1);
      selftest_done = (test_cnt == 1);
      dev_cnt = rst ? 0 : dev_req ? int'(delay) : (dev_cnt > 0) ? dev_cnt - 1 : 0;
      meas_cnt = rst ? 0 : meas_req ? int'(delay) : (meas_cnt > 0) ? meas_cnt - 1 : 0;
      test_cnt = rst ? 0 : selftest_req ? int'(delay) : (test_cnt > 0) ? test_cnt - 1 : 0;
   end
endmodule
`default_nettype wire

// ===== verif/common_command_handler_tb.sv
// Self-checking testbench for the common command handler.
`timescale 1ns/100ps
`default_nettype none
module common_command_handler_tb;
   logic clk, rst, cmd_valid, cmd_ready, resp_valid, resp_ready, msg_available, port_is_gpib;
   logic dev_req, dev_done, meas_req, meas_done, selftest_req, selftest_done, settings_reset;
   logic meas_seen, dev_busy;
   logic [3:0] selftest_faults;
   logic [7:0] sesr_set, sesr, lat;
   logic [7:0] device_event_reg_a, device_event_reg_b, device_event_reg_c, device_event_reg_d;
   logic [3:0][7:0] dev_event_set;
   cmd_handler_pkg::command_s cmd;
   cmd_handler_pkg::response_s resp, r;
   cmd_handler_pkg::level_e signal_level;
   int num_errors, samples_checked;
   logic [3:0] ft [3] = '{4'h2, 4'hF, 4'h0};
   logic [15:0] lm [6] = '{16'h0005, 16'h0001, 16'h1388, 16'h2714, 16'h1384, 16'h0002};
   logic [4:0] le [6] = '{5'h1F, 5'h00, 5'h1C, 5'h1C, 5'h1C, 5'h00};
   logic [5:0] ll = 6'h35;

   // Identity parameters are arbitrary values.
   common_command_handler #(.MAKER_CODE(16'h1234), .MODEL_CODE(16'h0042),
      .FW_VERSION(16'h0200)) dut (.clk, .rst, .cmd_valid, .cmd, .cmd_ready, .resp_valid,
      .resp_ready, .resp, .msg_available, .port_is_gpib, .dev_req, .dev_done, .meas_req,
      .meas_done, .selftest_req, .selftest_done, .selftest_faults, .settings_reset,
      .signal_level, .sesr_set, .dev_event_set, .sesr, .device_event_reg_a,
      .device_event_reg_b, .device_event_reg_c, .device_event_reg_d);
   back_end_model far (.clk, .rst, .dev_req, .meas_req, .selftest_req, .delay(lat),
      .dev_done, .meas_done, .selftest_done);

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Offers a command and returns at the falling edge after it was taken, valid still high.
   task automatic send(input cmd_handler_pkg::opcode_e op, input logic [15:0] m,
         input logic [4:0] e);
      int n = 0;
      cmd_valid = 1'b1;
      cmd = {op, m, e};
      #1;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         #1;
         n++;
      end
      if (n == 100) num_errors++;
      @(negedge clk);
   endtask

   // Waits for an answer, keeps it in r and takes it for one cycle.
   task automatic take;
      int n = 0;
      while (resp_valid !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) num_errors++;
      r = resp;
      resp_ready = 1'b1;
      @(negedge clk);
      resp_ready = 1'b0;
   endtask

   // Clock of 40 ns period.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cuts a hung run short.
   initial begin
      #400000;
      num_errors++;
      stop_test();
   end

   // Watches back end completions and the order of later commands.
   always @(posedge clk) begin
      if (cmd_valid && cmd_ready) check(dev_busy, 1'b0);
      if (dev_req) check(meas_seen, 1'b1);
      if (meas_done) meas_seen = 1'b1;
      dev_busy = rst ? 1'b0 : dev_req ? 1'b1 : dev_done ? 1'b0 : dev_busy;
   end

   // Main sequence of command calls with expected answers.
   initial begin
      rst = 1'b1;
      {cmd_valid, resp_ready, port_is_gpib, meas_seen, dev_busy} = 5'h09;
      cmd = '0;
      selftest_faults = 4'h0;
      sesr_set = 8'h00;
      dev_event_set = '0;
      lat = 8'h01;
      num_errors = 0;
      samples_checked = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      check({resp_valid, sesr, signal_level}, {1'b0, 8'h00, 1'b0});
      send(cmd_handler_pkg::OP_IDN_Q, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      take();
      check({r.kind, r.maker, r.model, r.zero_field, r.fw_version},
         {cmd_handler_pkg::RESP_IDN, 16'h1234, 16'h0042, 8'h00, 16'h0200});
      // Self test with three fault patterns, from a prompt and from a slow back end.
      for (int i = 0; i < 3; i++) begin
         selftest_faults = ft[i];
         lat = 8'h01 + 8'(i * 5);
         send(cmd_handler_pkg::OP_TST_Q, 16'h0000, 5'h00);
         cmd_valid = 1'b0;
         take();
         check({r.kind, r.value}, {cmd_handler_pkg::RESP_NR1, 12'h000, ft[i]});
      end
      // Levels in integer, fixed and floating notation, with rounding and one illegal value.
      for (int i = 0; i < 6; i++) begin
         send(cmd_handler_pkg::OP_LEVEL_SET, lm[i], le[i]);
         check(signal_level, ll[i]);
      end
      check(sesr[4], 1'b1);
      send(cmd_handler_pkg::OP_LEVEL_Q, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      take();
      check({r.kind, r.value}, {cmd_handler_pkg::RESP_LEVEL, 16'h01F4});
      // Completion flag waits for an outstanding fetch.
      lat = 8'h08;
      send(cmd_handler_pkg::OP_MEAS_Q, 16'h0000, 5'h00);
      send(cmd_handler_pkg::OP_OPC, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      check(sesr[0], 1'b0);
      repeat (12) @(negedge clk);
      check(sesr[0], 1'b1);
      meas_seen = 1'b0;
      send(cmd_handler_pkg::OP_MEAS_Q, 16'h0000, 5'h00);
      send(cmd_handler_pkg::OP_OPC_Q, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      check(resp_valid, 1'b0);
      take();
      check({meas_seen, r.kind, r.value}, {1'b1, cmd_handler_pkg::RESP_OPC, 16'h0031});
      // A wait between a fetch and a device command, then a command behind the device command.
      meas_seen = 1'b0;
      send(cmd_handler_pkg::OP_MEAS_Q, 16'h0000, 5'h00);
      send(cmd_handler_pkg::OP_WAI, 16'h0000, 5'h00);
      send(cmd_handler_pkg::OP_DEV_CMD, 16'h0000, 5'h00);
      send(cmd_handler_pkg::OP_IDN_Q, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      take();
      check(r.kind, cmd_handler_pkg::RESP_IDN);
      // Clearing events with an answer pending, on both ports.
      for (int g = 0; g < 2; g++) begin
         port_is_gpib = g[0];
         send(cmd_handler_pkg::OP_IDN_Q, 16'h0000, 5'h00);
         cmd_valid = 1'b0;
         sesr_set = 8'h20;
         dev_event_set = 32'h8142_2418;
         @(negedge clk);
         sesr_set = 8'h00;
         dev_event_set = '0;
         @(negedge clk);
         check({device_event_reg_a, device_event_reg_b, device_event_reg_c,
            device_event_reg_d, sesr[5]}, {32'h1824_4281, 1'b1});
         send(cmd_handler_pkg::OP_CLS, 16'h0000, 5'h00);
         cmd_valid = 1'b0;
         check({sesr, device_event_reg_a, device_event_reg_b, device_event_reg_c,
            device_event_reg_d}, 40'h0);
         check({resp_valid, msg_available}, 2'h3);
         take();
         check(r.kind, cmd_handler_pkg::RESP_IDN);
      end
      // Reset returns the level to its initial setting.
      send(cmd_handler_pkg::OP_LEVEL_SET, 16'h0005, 5'h1F);
      check(signal_level, cmd_handler_pkg::LEVEL_500MV);
      send(cmd_handler_pkg::OP_RST, 16'h0000, 5'h00);
      cmd_valid = 1'b0;
      check({settings_reset, signal_level}, {1'b1, cmd_handler_pkg::LEVEL_1V});
      @(negedge clk);
      check(settings_reset, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
